// ---- src/flpc_regs.sv ----
// FIFO level and power control registers behind an AHB-Lite slave.
// Assumes one bus master, word accesses, and the datapath FIFO levels.
//
// Summary of operation
// (RULE1) Rx status field reports used dwords
// (RULE2) Rx data field counts dword-rounded bytes
// (RULE3) Tx status field reports used dwords
// (RULE4) Tx free field resets to 1200h
// (RULE5) Host never overfills the tx data FIFO
// (RULE6) Power register readable in low power
// (RULE7) Writes blocked until one read done
// (RULE8) Power state self-clears, 11b reserved
// (RULE9) Byte test write wakes the device
// (RULE10) Host writes only byte test when unready
// (RULE11) Transceiver reset held 100us, then clears
// (RULE12) Transceiver reset writes ignored while high
// (RULE13) Lan wake drives pin when enabled
// (RULE14) Lan wake raises internal event irq
// (RULE15) Energy detect drives pin when enabled
// (RULE16) Energy detect raises internal event irq
// (RULE17) Bit 6 picks open drain or push-pull
// (RULE18) Ready bit set once device stable
// (RULE19) Pin enable gates pin, not irq
// (RULE20) Pulse style gives 50ms pulse
// (RULE21) Polarity bit sets push-pull active level
// (RULE22) Reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module flpc_regs (
	// System
	input  wire logic               hclk,
	input  wire logic               hresetn,
	// AHB-Lite slave
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	// Datapath levels and wake detectors
	input  wire flpc_pkg::flpc_levels_t levels,
	input  wire flpc_pkg::flpc_wake_t   wake,
	// Power outputs
	output logic [1:0]              power_state_select,
	output logic                    transceiver_reset,
	output logic                    power_event_irq,
	output logic                    power_event_pin_out,
	output logic                    power_event_pin_oe
);
	////////////////////////////////////////////////////////////////////////
	// Bus address phase capture
	logic        ph_valid;
	logic        ph_write;
	logic [7:0]  ph_addr;
	logic        addr_ok;
	logic        wr_fire;
	logic        rd_fire;

	// Only word-aligned word writes are decoded; reads decode haddr[7:0] alone
	assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);

	// Register the address phase for the following data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr  <= 8'h00;
		end else if (hready) begin
			ph_valid <= hsel && htrans[1] && addr_ok && (hsize == 3'h2);
			ph_write <= hwrite;
			ph_addr  <= haddr[7:0];
		end
	end
	assign wr_fire = ph_valid && ph_write;
	assign rd_fire = hsel && htrans[1] && hready && !hwrite;

	// Zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read-before-write unlock and readiness
	logic read_seen;
	logic ready;
	logic wake_req;
	logic settling;
	logic wr_ok;
	logic low_power;
	logic bt_write;

	assign low_power = (power_state_select != flpc_pkg::PSTATE_D0);
	assign bt_write  = wr_fire && (ph_addr == flpc_pkg::BYTE_TEST_OFS);
	// Writes count only after a read and while ready; the byte test wake needs neither
	assign wr_ok = wr_fire && read_seen && ready; // RULE7

	// Cleared by reset, by sleep entry and by wake; a read reopens writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			read_seen <= 1'b0;
		end else if (rd_fire) begin
			read_seen <= 1'b1; // RULE7
		end else if (wake_req || (wr_ok && ph_addr == flpc_pkg::PWR_CTRL_OFS
				&& hwdata[flpc_pkg::PSTATE_LSB +: 2] != flpc_pkg::PSTATE_D0)) begin
			read_seen <= 1'b0;
		end
	end

	// Any write to byte test while asleep starts the wake-up
	assign wake_req = bt_write && low_power; // RULE9

	flpc_timer #(
		.CYCLES (flpc_pkg::WAKE_SETTLE_CYC)
	) u_settle (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (wake_req),
		.stop    (1'b0),
		.busy    (settling)
	);

	// Ready drops in sleep, returns after settling
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ready <= 1'b1;
		end else begin
			ready <= !low_power && !settling && !wake_req; // RULE18
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control fields
	logic event_out_enable;
	logic event_out_polarity;
	logic event_out_pulse_style;
	logic event_out_buffer_type;
	logic energy_detect_enable;
	logic lan_wake_enable;
	logic pwr_wr;
	logic rst_busy;
	logic rst_start;

	assign pwr_wr = wr_ok && (ph_addr == flpc_pkg::PWR_CTRL_OFS);

	// Plain read/write configuration bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			event_out_enable      <= 1'b0;
			event_out_polarity    <= 1'b0;
			event_out_pulse_style <= 1'b0;
			event_out_buffer_type <= 1'b0;
			energy_detect_enable  <= 1'b0;
			lan_wake_enable       <= 1'b0;
		end else if (pwr_wr) begin
			event_out_enable      <= hwdata[flpc_pkg::EV_EN_BIT];
			event_out_polarity    <= hwdata[flpc_pkg::EV_POL_BIT];
			event_out_pulse_style <= hwdata[flpc_pkg::EV_PULSE_BIT];
			event_out_buffer_type <= hwdata[flpc_pkg::EV_TYPE_BIT];
			energy_detect_enable  <= hwdata[flpc_pkg::ENERGY_DETECT_ENABLE_BIT];
			lan_wake_enable       <= hwdata[flpc_pkg::LAN_WAKE_ENABLE_BIT];
		end
	end

	// Power state: set by write, cleared by wake; reserved code dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			power_state_select <= flpc_pkg::PSTATE_RST;
		end else if (wake_req) begin
			power_state_select <= flpc_pkg::PSTATE_D0; // RULE8
		end else if (pwr_wr && hwdata[flpc_pkg::PSTATE_LSB +: 2] != flpc_pkg::PSTATE_RSV) begin
			power_state_select <= hwdata[flpc_pkg::PSTATE_LSB +: 2]; // RULE8
		end
	end

	// Start only when the timer is idle, so a write while high is ignored except in the last high cycle
	assign rst_start = pwr_wr && hwdata[flpc_pkg::XCVR_RST_BIT] && !rst_busy; // RULE12

	flpc_timer #(
		.CYCLES (flpc_pkg::XCVR_RST_CYC)
	) u_xrst (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (rst_start),
		.stop    (1'b0),
		.busy    (rst_busy)
	);

	// Reset held for the full count then self-clears
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			transceiver_reset <= 1'b0;
		end else begin
			transceiver_reset <= rst_start || (rst_busy && !(transceiver_reset && !rst_busy)); // RULE11
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wake events, internal irq and pin
	logic ev_hit;
	logic ev_latched;
	logic pulse_busy;
	logic pin_active;

	// Enabled sources, independent of the pin enable
	assign ev_hit = (wake.lan_wake && lan_wake_enable)
		|| (wake.energy && energy_detect_enable); // RULE14 RULE16

	// Level until the enables are dropped; a new hit wins over the clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ev_latched <= 1'b0;
		end else if (ev_hit) begin
			ev_latched <= 1'b1;
		end else if (!lan_wake_enable && !energy_detect_enable) begin
			ev_latched <= 1'b0;
		end
	end

	// Internal irq ignores the pin enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			power_event_irq <= 1'b0;
		end else begin
			power_event_irq <= ev_latched; // RULE14 RULE16 RULE19
		end
	end

	flpc_timer #(
		.CYCLES (flpc_pkg::EV_PULSE_CYC)
	) u_pulse (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (ev_hit && !ev_latched),
		.stop    (!event_out_enable),
		.busy    (pulse_busy)
	);

	// Pulse or static, gated by the pin enable
	assign pin_active = event_out_enable
		&& (event_out_pulse_style ? pulse_busy : ev_latched); // RULE13 RULE15 RULE19 RULE20

	flpc_event_out u_pin (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.push_pull   (event_out_buffer_type), // RULE17
		.active_high (event_out_polarity),
		.asserted    (pin_active),
		.pin_out     (power_event_pin_out),
		.pin_oe      (power_event_pin_oe)
	);

	////////////////////////////////////////////////////////////////////////
	// Read data
	logic [31:0] next_rdata;

	// Reserved bits zero; power register always readable
	always_comb begin
		next_rdata = 32'h00000000; // RULE22
		unique case (haddr[7:0])
			flpc_pkg::RX_LEVELS_OFS: begin
				next_rdata[flpc_pkg::STAT_USED_LSB +: 8] = levels.rx_status_used_dwords; // RULE1
				next_rdata[flpc_pkg::DATA_LSB +: 16]     = levels.rx_data_used_bytes; // RULE2
			end
			flpc_pkg::TX_LEVELS_OFS: begin
				next_rdata[flpc_pkg::STAT_USED_LSB +: 8] = levels.tx_status_used_dwords; // RULE3
				next_rdata[flpc_pkg::DATA_LSB +: 16]     = levels.tx_data_free_bytes; // RULE4
			end
			flpc_pkg::PWR_CTRL_OFS: begin
				next_rdata[flpc_pkg::PSTATE_LSB +: 2]     = power_state_select; // RULE6
				next_rdata[flpc_pkg::XCVR_RST_BIT]        = transceiver_reset;
				next_rdata[flpc_pkg::LAN_WAKE_ENABLE_BIT]          = lan_wake_enable;
				next_rdata[flpc_pkg::ENERGY_DETECT_ENABLE_BIT]           = energy_detect_enable;
				next_rdata[flpc_pkg::EV_TYPE_BIT]         = event_out_buffer_type;
				next_rdata[flpc_pkg::EV_PULSE_BIT]        = event_out_pulse_style;
				next_rdata[flpc_pkg::EV_POL_BIT]          = event_out_polarity;
				next_rdata[flpc_pkg::EV_EN_BIT]           = event_out_enable;
				next_rdata[flpc_pkg::READY_BIT]           = ready; // RULE18
			end
			default: begin
				next_rdata = 32'h00000000;
			end
		endcase
	end

	// Data captured at the address phase, shown in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_fire) begin
			hrdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic [15:0] rst_len;

	// Length of the current transceiver reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_len <= 16'h0000;
		end else if (transceiver_reset) begin
			rst_len <= rst_len + 16'h0001;
		end else begin
			rst_len <= 16'h0000;
		end
	end

	xrst_min_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE11
		$fell(transceiver_reset) |-> rst_len >= 16'(flpc_pkg::XCVR_RST_CYC))
		else $error("transceiver reset released early");
	// A restart while high would stretch the hold past one count
	xrst_ignore_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE12
		transceiver_reset |-> rst_len <= 16'(flpc_pkg::XCVR_RST_CYC))
		else $error("transceiver reset restarted while high");
	wr_lock_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
		!read_seen && wr_fire && ph_addr == flpc_pkg::PWR_CTRL_OFS
		|=> $stable(lan_wake_enable) && $stable(event_out_enable))
		else $error("write accepted before a read");
	pstate_rsv_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
		power_state_select != flpc_pkg::PSTATE_RSV)
		else $error("reserved power state held");
	wake_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
		wake_req |=> power_state_select == flpc_pkg::PSTATE_D0 && !ready)
		else $error("byte test write did not wake");
	irq_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE14
		wake.lan_wake && lan_wake_enable |=> ##1 power_event_irq)
		else $error("lan wake did not raise irq");
	irq_ed_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE16
		wake.energy && energy_detect_enable |=> ##1 power_event_irq)
		else $error("energy detect did not raise irq");
	pin_gate_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE19
		!event_out_enable && !event_out_buffer_type |=> !power_event_pin_oe)
		else $error("open drain pin driven while disabled");
	od_low_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE17
		power_event_pin_oe && !$past(event_out_buffer_type) |-> !power_event_pin_out)
		else $error("open drain pin driven high");
	ready_sleep_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE18
		low_power |=> !ready)
		else $error("ready set in low power");

	xrst_c: cover property (@(posedge hclk) disable iff (!hresetn) $fell(transceiver_reset));
	wake_c: cover property (@(posedge hclk) disable iff (!hresetn) wake_req);
	pulse_c: cover property (@(posedge hclk) disable iff (!hresetn) $fell(pulse_busy));
endmodule : flpc_regs
`default_nettype wire

// ---- src/flpc_pkg.sv ----
// Package for the FIFO level and power control register bank.
// Assumes an AHB-Lite slave on a 20 MHz system clock.
package flpc_pkg;
	// Register byte offsets
	localparam logic [7:0] RX_LEVELS_OFS   = 8'h7c;
	localparam logic [7:0] TX_LEVELS_OFS   = 8'h80;
	localparam logic [7:0] PWR_CTRL_OFS    = 8'h84;
	localparam logic [7:0] BYTE_TEST_OFS   = 8'h64;
	// Level field positions
	localparam int STAT_USED_LSB = 16;
	localparam int DATA_LSB      = 0;
	// Power control field positions
	localparam int READY_BIT     = 0;
	localparam int EV_EN_BIT     = 1;
	localparam int EV_POL_BIT    = 2;
	localparam int EV_PULSE_BIT  = 3;
	localparam int EV_TYPE_BIT   = 6;
	localparam int ENERGY_DETECT_ENABLE_BIT     = 8;
	localparam int LAN_WAKE_ENABLE_BIT    = 9;
	localparam int XCVR_RST_BIT  = 10;
	localparam int PSTATE_LSB    = 12;
	// Reset values
	localparam logic [7:0]  STAT_USED_RST = 8'h00;
	localparam logic [15:0] RX_DATA_RST   = 16'h0000;
	localparam logic [15:0] TX_FREE_RST   = 16'h1200;
	localparam logic [1:0]  PSTATE_RST    = 2'h0;
	// Power states
	localparam logic [1:0] PSTATE_D0 = 2'h0;
	localparam logic [1:0] PSTATE_D1 = 2'h1;
	localparam logic [1:0] PSTATE_D2 = 2'h2;
	localparam logic [1:0] PSTATE_RSV = 2'h3;
	// Timing
	localparam int CLK_HZ        = 20000000;
	localparam int XCVR_RST_US   = 100;
	localparam int EV_PULSE_MS   = 50;
	localparam int XCVR_RST_CYC  = (XCVR_RST_US * (CLK_HZ / 1000000));
	localparam int EV_PULSE_CYC  = (EV_PULSE_MS * (CLK_HZ / 1000));
	localparam int WAKE_SETTLE_CYC = 16;
	// FIFO level update from the datapath
	typedef struct packed {
		logic [7:0]  rx_status_used_dwords;
		logic [15:0] rx_data_used_bytes;
		logic [7:0]  tx_status_used_dwords;
		logic [15:0] tx_data_free_bytes;
	} flpc_levels_t;
	// Wake event inputs
	typedef struct packed {
		logic lan_wake;
		logic energy;
	} flpc_wake_t;
endpackage : flpc_pkg

// ---- src/flpc_timer.sv ----
// Down counter that holds its busy output for a load-time count.
// Assumes start is a one-cycle pulse in the hclk domain.
`timescale 1ns/1ps
`default_nettype none
module flpc_timer #(
	parameter int CYCLES = 16
) (
	// System
	input  wire logic hclk,
	input  wire logic hresetn,
	// Control
	input  wire logic start,
	input  wire logic stop,
	output logic      busy
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LOAD = W'(CYCLES);
	logic [W-1:0] count;

	// Load on start, count to zero; stop wins over a running count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= '0;
		end else if (stop) begin
			count <= '0;
		end else if (start) begin
			count <= LOAD;
		end else if (count != '0) begin
			count <= count - W'(1);
		end
	end
	assign busy = (count != '0);
endmodule : flpc_timer
`default_nettype wire

// ---- src/flpc_event_out.sv ----
// Power event pin driver: buffer type and polarity; pulse style applied by the caller.
// Assumes the event request is level and the timer is external.
`timescale 1ns/1ps
`default_nettype none
module flpc_event_out (
	// System
	input  wire logic hclk,
	input  wire logic hresetn,
	// Configuration
	input  wire logic push_pull,
	input  wire logic active_high,
	// Event state
	input  wire logic asserted,
	// Pin
	output logic      pin_out,
	output logic      pin_oe
);
	// Open drain pulls low only when active; polarity ignored there
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_out <= 1'b0;
			pin_oe  <= 1'b0;
		end else if (push_pull) begin
			pin_out <= asserted ~^ active_high; // RULE21
			pin_oe  <= 1'b1;
		end else begin
			pin_out <= 1'b0; // RULE17
			pin_oe  <= asserted;
		end
	end
endmodule : flpc_event_out
`default_nettype wire

// ---- tb/flpc_host_model.sv ----
// Host processor model: an AHB-Lite master doing single word transfers.
// Assumes one slave whose hreadyout is returned as hready.
`timescale 1ns/1ps
`default_nettype none
module flpc_host_model (
	// System
	input  wire logic        hclk,
	// AHB-Lite master
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	input  wire logic [31:0] hrdata,
	input  wire logic        hready
);
	////////////////////////////////////////////////////////////////////////////////
	// Idle bus from time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One transfer; register words only, never a data FIFO push
	task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] d,
			output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? d : ~hwdata;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
		// Released data inverted so a stale word cannot pass for a fresh one
		hwdata <= ~hwdata;
	endtask : xfer
endmodule : flpc_host_model
`default_nettype wire

// ---- tb/fifo_level_and_power_ctrl_regs_tb.sv ----
// Self-checking bench for the FIFO level and power control registers.
// Assumes the host model drives the bus and the bench drives levels and wake.
`timescale 1ns/1ps
`default_nettype none
module fifo_level_and_power_ctrl_regs_tb;
	localparam logic [7:0] PWR = flpc_pkg::PWR_CTRL_OFS;
	localparam int         XRC = flpc_pkg::XCVR_RST_CYC;
	logic                   hclk;
	logic                   hresetn;
	logic                   hsel;
	logic [31:0]            haddr;
	logic [1:0]             htrans;
	logic                   hwrite;
	logic [2:0]             hsize;
	logic [31:0]            hwdata;
	logic [31:0]            hrdata;
	logic                   hreadyout;
	logic                   hresp;
	flpc_pkg::flpc_levels_t levels;
	flpc_pkg::flpc_wake_t   wake;
	logic [1:0]             power_state_select;
	logic                   transceiver_reset;
	logic                   power_event_irq;
	logic                   power_event_pin_out;
	logic                   power_event_pin_oe;
	logic                   pin_level;
	int                     n_mismatch;
	int                     tests_run;
	int                     cycles;
	int                     xr_cycles;

	////////////////////////////////////////////////////////////////////////////////
	// Design, host and pulled-up event wire
	flpc_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.levels(levels), .wake(wake), .power_state_select(power_state_select),
		.transceiver_reset(transceiver_reset), .power_event_irq(power_event_irq),
		.power_event_pin_out(power_event_pin_out), .power_event_pin_oe(power_event_pin_oe));
	flpc_host_model u_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
		.hready(hreadyout));
	assign pin_level = (power_event_pin_oe === 1'b1) ? power_event_pin_out : 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// 50 ns clock, hang limit and transceiver reset length counter
	initial hclk = 1'b0;
	always #25 hclk = ~hclk;
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (transceiver_reset === 1'b1) xr_cycles <= xr_cycles + 1;
		if (cycles == 12000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic bus_wr(input logic [7:0] ofs, input logic [31:0] d);
		logic [31:0] unused;
		u_host.xfer({24'h0, ofs}, 1'b1, d, unused);
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] ofs, output logic [31:0] rd);
		u_host.xfer({24'h0, ofs}, 1'b0, 32'h0, rd);
	endtask : bus_rd

	// Polls until ready; these reads also unlock writes
	task automatic rd_ready(output logic [31:0] rd);
		for (int i = 0; i < 64; i++) begin
			bus_rd(PWR, rd);
			if (rd[0] === 1'b1) break;
		end
	endtask : rd_ready

	task automatic wrap_up;
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_lock;
		logic [31:0] rd;
		bus_wr(PWR, 32'h0000_0002);
		rd_ready(rd);
		chk(rd, 32'h0000_0001);
		bus_wr(PWR, 32'h0000_0002);
		bus_rd(PWR, rd);
		chk(rd, 32'h0000_0003);
		bus_rd(8'h88, rd);
		chk(rd, 32'h0000_0000);
		chk({31'h0, hresp}, 32'h0);
		bus_wr(PWR, 32'hffff_c8b0);
		bus_rd(PWR, rd);
		chk(rd, 32'h0000_0001);
	endtask : t_lock

	task automatic t_levels;
		logic [31:0] rd;
		bus_rd(flpc_pkg::RX_LEVELS_OFS, rd);
		chk(rd, 32'h0000_0000);
		bus_rd(flpc_pkg::TX_LEVELS_OFS, rd);
		chk(rd, 32'h0000_1200);
		@(posedge hclk);
		levels <= {8'hff, 16'hfffc, 8'h80, 16'h0004};
		bus_rd(flpc_pkg::RX_LEVELS_OFS, rd);
		chk(rd, 32'h00ff_fffc);
		bus_rd(flpc_pkg::TX_LEVELS_OFS, rd);
		chk(rd, 32'h0080_0004);
	endtask : t_levels

	task automatic t_power;
		logic [31:0] rd;
		bus_wr(PWR, 32'h0000_3000);
		bus_rd(PWR, rd);
		chk(rd, 32'h0000_0001);
		for (int st = 1; st <= 2; st++) begin
			bus_wr(PWR, 32'(st) << 12);
			@(negedge hclk);
			chk({30'h0, power_state_select}, 32'(st));
			bus_rd(PWR, rd);
			chk(rd & 32'h0000_3001, 32'(st) << 12);
			// Only the byte test word is written while unready
			bus_wr(flpc_pkg::BYTE_TEST_OFS, 32'h0);
			rd_ready(rd);
			chk(rd, 32'h0000_0001);
			chk({30'h0, power_state_select}, 32'h0);
		end
	endtask : t_power

	task automatic t_xcvr;
		logic [31:0] rd;
		xr_cycles = 0;
		bus_wr(PWR, 32'h0000_0400);
		@(negedge hclk);
		chk({31'h0, transceiver_reset}, 32'h1);
		bus_rd(PWR, rd);
		chk(rd, 32'h0000_0401);
		repeat (1000) @(posedge hclk);
		// A second set must not restart the hold
		bus_wr(PWR, 32'h0000_0400);
		for (int i = 0; i < 4000 && transceiver_reset === 1'b1; i++) @(posedge hclk);
		@(negedge hclk);
		chk({31'h0, xr_cycles >= XRC && xr_cycles <= XRC + 4}, 32'h1);
		bus_rd(PWR, rd);
		chk(rd, 32'h0000_0001);
	endtask : t_xcvr

	// One wake event under a given configuration, then enables cleared
	task automatic ev_case(input logic lan, input logic [31:0] cfg);
		logic en;
		logic act;
		logic exp_pin;
		en = lan ? cfg[9] : cfg[8];
		act = cfg[6] ? cfg[2] : 1'b0;
		exp_pin = (en & cfg[1]) ? act : ~act;
		bus_wr(PWR, cfg);
		// Pin register follows the new configuration one cycle late
		repeat (2) @(negedge hclk);
		chk({31'h0, pin_level}, {31'h0, ~act});
		@(posedge hclk);
		if (lan) wake.lan_wake <= 1'b1;
		else wake.energy <= 1'b1;
		@(posedge hclk);
		wake <= '0;
		// Let a wrong reaction show before the outputs are judged
		repeat (3) @(posedge hclk);
		for (int i = 0; i < 8 && (power_event_irq !== en || pin_level !== exp_pin); i++)
			@(posedge hclk);
		@(negedge hclk);
		chk({31'h0, power_event_irq}, {31'h0, en});
		chk({31'h0, pin_level}, {31'h0, exp_pin});
		bus_wr(PWR, 32'h0);
		for (int i = 0; i < 8 && (power_event_irq !== 1'b0 || pin_level !== 1'b1); i++)
			@(posedge hclk);
		@(negedge hclk);
		chk({30'h0, power_event_irq, pin_level}, 32'h1);
	endtask : ev_case

	task automatic t_events;
		ev_case(1'b1, 32'h0000_0206);
		ev_case(1'b1, 32'h0000_0200);
		ev_case(1'b0, 32'h0000_0146);
		ev_case(1'b0, 32'h0000_0142);
		ev_case(1'b1, 32'h0000_024e);
		ev_case(1'b0, 32'h0000_0202);
	endtask : t_events

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		hresetn = 1'b0;
		levels = {8'h00, 16'h0000, 8'h00, 16'h1200};
		wake = '0;
		n_mismatch = 0;
		tests_run = 0;
		cycles = 0;
		xr_cycles = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_lock();
		t_levels();
		t_power();
		t_xcvr();
		t_events();
		wrap_up();
	end
endmodule : fifo_level_and_power_ctrl_regs_tb
`default_nettype wire
